//--- src/npt_consts.vh
`ifndef NPT_CONSTS_VH
`define NPT_CONSTS_VH

// register bus geometry
`define NPT_ADDR_W          5
`define NPT_DATA_W          16

// register offset
`define NPT_OFS_NEXT_PAGE   5'h07

// field positions
`define NPT_BIT_MORE_PAGES  15
`define NPT_BIT_RESERVED    14
`define NPT_BIT_MSG_PAGE    13
`define NPT_BIT_COMPLY_ACK  12
`define NPT_BIT_ALT         11
`define NPT_CODE_HI         10
`define NPT_CODE_LO         0
`define NPT_CODE_W          11

// reset values
`define NPT_RST_MORE_PAGES  1'h0
`define NPT_RST_MSG_PAGE    1'h1
`define NPT_RST_COMPLY_ACK  1'h0
`define NPT_RST_ALT         1'h0
`define NPT_RST_CODE        11'h001
`define NPT_RD_ZERO         16'h0000
`define NPT_RSV_VAL         1'h0
`define NPT_RVALID_IDLE     1'h0

`endif

//--- src/npt_next_page_tx.v
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "npt_consts.vh"

module npt_next_page_tx (
    input  wire                     clk_sys,
    input  wire                     nrst,
    input  wire [`NPT_ADDR_W-1:0]   reg_addr,
    input  wire [`NPT_DATA_W-1:0]   reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [`NPT_DATA_W-1:0]   reg_rdata,
    output reg                      reg_rvalid,
    input  wire                     an_restart,
    input  wire                     page_exchanged,
    input  wire                     exchanged_toggle,
    output wire [`NPT_DATA_W-1:0]   tx_page
);

    // register fields
    reg                         more_pages_flag;
    reg                         message_page_select;
    reg                         comply_acknowledge;
    reg                         alternation_bit;
    reg  [`NPT_CODE_W-1:0]      code_field;

    // next values
    reg                         next_more_pages_flag;
    reg                         next_message_page_select;
    reg                         next_comply_acknowledge;
    reg                         next_alternation_bit;
    wire [`NPT_CODE_W-1:0]      next_code_field;
    reg  [`NPT_DATA_W-1:0]      next_reg_rdata;
    reg                         next_reg_rvalid;

    // write data split into fields
    wire                        wdata_more_pages;
    wire                        wdata_msg_page;
    wire                        wdata_comply_ack;
    wire [`NPT_CODE_W-1:0]      wdata_code;

    // decode and assembled word
    wire                        hit;
    wire                        wr_hit;
    wire                        rd_hit;
    wire                        reserved_bit;
    wire [`NPT_DATA_W-1:0]      next_page_transmit;

    // reset image of the code field, taken per bit
    localparam [`NPT_CODE_W-1:0] code_rst = `NPT_RST_CODE;

    assign hit    = (reg_addr == `NPT_OFS_NEXT_PAGE);
    assign wr_hit = reg_wr & hit;
    assign rd_hit = reg_rd & hit;

    // bit 11 and bit 14 of the write word are dropped here
    assign wdata_more_pages = reg_wdata[`NPT_BIT_MORE_PAGES];
    assign wdata_msg_page   = reg_wdata[`NPT_BIT_MSG_PAGE];
    assign wdata_comply_ack = reg_wdata[`NPT_BIT_COMPLY_ACK];
    assign wdata_code       = reg_wdata[`NPT_CODE_HI:`NPT_CODE_LO];

    // reserved position stores nothing
    assign reserved_bit = `NPT_RSV_VAL;

    assign next_page_transmit = {more_pages_flag,
                                 reserved_bit,
                                 message_page_select,
                                 comply_acknowledge,
                                 alternation_bit,
                                 code_field};

    // word handed to the arbitration logic
    assign tx_page = next_page_transmit;

    // more pages flag
    always @* begin
        case (wr_hit)
            1'h1: begin
                next_more_pages_flag = wdata_more_pages;
            end

            1'h0: begin
                next_more_pages_flag = more_pages_flag;
            end

            default: begin
                next_more_pages_flag = more_pages_flag;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            more_pages_flag <= `NPT_RST_MORE_PAGES;
        end else begin
            more_pages_flag <= next_more_pages_flag;
        end
    end

    // message or unformatted page select
    always @* begin
        case (wr_hit)
            1'h1: begin
                next_message_page_select = wdata_msg_page;
            end

            1'h0: begin
                next_message_page_select = message_page_select;
            end

            default: begin
                next_message_page_select = message_page_select;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            message_page_select <= `NPT_RST_MSG_PAGE;
        end else begin
            message_page_select <= next_message_page_select;
        end
    end

    // comply acknowledge
    always @* begin
        case (wr_hit)
            1'h1: begin
                next_comply_acknowledge = wdata_comply_ack;
            end

            1'h0: begin
                next_comply_acknowledge = comply_acknowledge;
            end

            default: begin
                next_comply_acknowledge = comply_acknowledge;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            comply_acknowledge <= `NPT_RST_COMPLY_ACK;
        end else begin
            comply_acknowledge <= next_comply_acknowledge;
        end
    end

    // code field, one flop per bit
    genvar gi;

    generate
        for (gi = 0; gi < `NPT_CODE_W; gi = gi + 1) begin : g_code

            assign next_code_field[gi] = wr_hit ? wdata_code[gi]
                                                : code_field[gi];

            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    code_field[gi] <= code_rst[gi];
                end else begin
                    code_field[gi] <= next_code_field[gi];
                end
            end

        end
    endgenerate

    // toggle owned by arbitration; software writes never reach it
    always @* begin
        case ({an_restart, page_exchanged})
            2'h0: begin
                next_alternation_bit = alternation_bit;
            end

            2'h1: begin
                next_alternation_bit = ~exchanged_toggle;
            end

            2'h2, 2'h3: begin
                // restart beats a same-cycle exchange
                next_alternation_bit = `NPT_RST_ALT;
            end

            default: begin
                next_alternation_bit = alternation_bit;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            alternation_bit <= `NPT_RST_ALT;
        end else begin
            alternation_bit <= next_alternation_bit;
        end
    end

    // read data stands only in the cycle after the strobe
    always @* begin
        next_reg_rvalid = reg_rd;
        case (rd_hit)
            1'h1: begin
                next_reg_rdata = next_page_transmit;
            end

            1'h0: begin
                // unmapped offsets and idle cycles read as zero
                next_reg_rdata = `NPT_RD_ZERO;
            end

            default: begin
                next_reg_rdata = `NPT_RD_ZERO;
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata  <= `NPT_RD_ZERO;
            reg_rvalid <= `NPT_RVALID_IDLE;
        end else begin
            reg_rdata  <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

endmodule // npt_next_page_tx
`default_nettype wire

//--- bench/npt_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module npt_chk (input wire logic clk_sys, nrst, reg_wr, reg_rd, reg_rvalid,
    page_exchanged, an_restart, exchanged_toggle,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata, tx_page);
wire w = reg_wr && reg_addr == 5'h07;
default clocking @(posedge clk_sys); endclocking
default disable iff (!nrst);
a_read_word: assert property (reg_rd && reg_addr == 5'h07 |=>
    reg_rdata == $past(tx_page)) else $error("rd");
a_field_write: assert property (w |=>
    (tx_page & 16'hF7FF) == ($past(reg_wdata) & 16'hB7FF)) else $error("wr");
a_alt_bit: assert property (page_exchanged && !an_restart |=>
    tx_page[11] != $past(exchanged_toggle)) else $error("alt");
a_rvalid_pulse: assert property (
    reg_rvalid == $past(reg_rd)) else $error("rvalid");
a_unmapped_zero: assert property (
    reg_rd && reg_addr != 5'h07 |=> reg_rdata == 16'h0000)
    else $error("unmapped");
a_reserved_zero: assert property (
    tx_page[14] == 1'h0) else $error("reserved");
a_restart_clear: assert property (
    an_restart |=> tx_page[11] == 1'h0) else $error("restart");
a_hold_no_write: assert property (
    !w |=> (tx_page & 16'hF7FF) == ($past(tx_page) & 16'hF7FF))
    else $error("hold");
endmodule // npt_chk
bind npt_next_page_tx npt_chk u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
    .page_exchanged(page_exchanged), .an_restart(an_restart),
    .exchanged_toggle(exchanged_toggle), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_page(tx_page));
`default_nettype wire

//--- bench/npt_lp.sv
`timescale 1ns/100ps
`default_nettype none
module npt_lp (input wire logic clk_sys, go,
    output logic page_exchanged = 1'h0, exchanged_toggle = 1'h0);
always @(posedge clk_sys) page_exchanged <= go;
always @(posedge clk_sys) if (go) exchanged_toggle <= !exchanged_toggle;
endmodule // npt_lp
`default_nettype wire

//--- bench/npt_test.sv
`timescale 1ns/100ps
`default_nettype none
module autoneg_next_page_tx_register_test;
logic clk_sys = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0;
logic an_restart = 1'h0, reg_rvalid, page_exchanged, exchanged_toggle;
logic [4:0] reg_addr = 5'h07;
logic [15:0] reg_wdata = 16'h0000, reg_rdata, tx_page;
logic [15:0] r [4] = '{16'hFFFF, 16'hB7FF, 16'h5001, 16'h1001};
int errors = 0, cmp_count = 0;
npt_next_page_tx u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .an_restart(an_restart),
    .page_exchanged(page_exchanged), .exchanged_toggle(exchanged_toggle),
    .tx_page(tx_page));
npt_lp u_lp (.clk_sys(clk_sys), .go(go), .page_exchanged(page_exchanged),
    .exchanged_toggle(exchanged_toggle));
initial forever #50 clk_sys = !clk_sys;
task ck(string n, logic [15:0] e, s);
    cmp_count++;
    if (s !== e) begin
        errors++;
        $display("mismatch %s exp %h got %h", n, e, s);
    end
endtask
task acc(logic w, logic [4:0] a, logic [15:0] v);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'h0;
    #1;
endtask
task tally_and_finish;
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'h1;
    ck("tx_page rst", 16'h2001, tx_page);
    acc(1'h0, 5'h07, 16'h0000);
    ck("rdata", 16'h2001, reg_rdata);
    ck("rvalid", 16'h0001, {15'h0000, reg_rvalid});
    @(posedge clk_sys);
    #1 ck("rdata idle", 16'h0000, reg_rdata);
    ck("rvalid idle", 16'h0000, {15'h0000, reg_rvalid});
    for (int i = 0; i < 4; i += 2) begin
        acc(1'h1, 5'h07, r[i]);
        ck("rvalid wr", 16'h0000, {15'h0000, reg_rvalid});
        acc(1'h0, 5'h07, 16'h0000);
        ck("rdata", r[i + 1], reg_rdata);
    end
    acc(1'h1, 5'h06, 16'hFFFF);
    acc(1'h0, 5'h06, 16'h0000);
    ck("rdata unmapped", 16'h0000, reg_rdata);
    ck("tx_page", 16'h1001, tx_page);
    // two exchanges back to back, toggle 1 then 0
    @(posedge clk_sys);
    go <= 1'h1;
    repeat (2) @(posedge clk_sys);
    go <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1 ck("tx_page alt", 16'h1801, tx_page);
    @(posedge clk_sys);
    an_restart <= 1'h1;
    @(posedge clk_sys);
    an_restart <= 1'h0;
    #1 ck("tx_page restart", 16'h1001, tx_page);
    acc(1'h1, 5'h07, 16'h9ABC);
    ck("tx_page wr", 16'h92BC, tx_page);
    @(posedge clk_sys);
    nrst <= 1'h0;
    @(posedge clk_sys);
    #1 ck("tx_page rst2", 16'h2001, tx_page);
    @(posedge clk_sys);
    nrst <= 1'h1;
    acc(1'h0, 5'h07, 16'h0000);
    ck("rdata rst2", 16'h2001, reg_rdata);
    tally_and_finish;
end
endmodule // autoneg_next_page_tx_register_test
`default_nettype wire
